/* ivm_pkg.sv */
package ivm_pkg;

    // register indices on the plain register port
    localparam logic [5:0] IVM_REG_CONTROL  = 6'h00;
    localparam logic [5:0] IVM_REG_TRAP     = 6'h01;
    localparam logic [5:0] IVM_REG_FLAG0    = 6'h04;
    localparam logic [5:0] IVM_REG_ENABLE0  = 6'h0C;
    localparam logic [5:0] IVM_REG_PRIO0    = 6'h14;
    localparam logic [5:0] IVM_REG_VECTOR   = 6'h20;
    localparam logic [5:0] IVM_REG_LEVEL    = 6'h21;

    // word counts and field positions
    localparam int         IVM_FLAG_WORDS   = 5;
    localparam int         IVM_PRIO_WORDS   = 7;
    localparam int         IVM_NUM_SRC      = 8;
    localparam int         IVM_NUM_TRAP     = 4;
    localparam int         IVM_ALT_BIT      = 15;

    // reset values
    localparam logic [15:0] IVM_WORD_RESET  = 16'h0000;
    localparam logic [3:0]  IVM_TRAP_RESET  = 4'h0;

    // vector table layout, program-memory word addresses
    localparam logic [23:0] IVM_TRAP_BASE   = 24'h00_0004;
    localparam logic [23:0] IVM_IRQ_BASE    = 24'h00_0014;
    localparam logic [23:0] IVM_ALT_OFFSET  = 24'h00_0100;
    localparam logic [3:0]  IVM_TRAP_LEVEL  = 4'hF;

    // per-source map, index order = ascending vector number
    // 0 ext pin 0, 1 conversion done, 2 memory write done, 3 change notify,
    // 4 ext pin 1, 5 rtc calendar, 6 voltage detect, 7 low-power wake-up
    localparam logic [6:0] IVM_SRC_VEC  [IVM_NUM_SRC] = '{7'h00, 7'h0D, 7'h0F, 7'h13, 7'h14, 7'h3E, 7'h48, 7'h50};
    localparam logic [2:0] IVM_SRC_FW   [IVM_NUM_SRC] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4};
    localparam logic [3:0] IVM_SRC_FB   [IVM_NUM_SRC] = '{4'h0, 4'hD, 4'hF, 4'h3, 4'h4, 4'hE, 4'h8, 4'h0};
    localparam logic [2:0] IVM_SRC_PW   [IVM_NUM_SRC] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    localparam logic [3:0] IVM_SRC_PL   [IVM_NUM_SRC] = '{4'h0, 4'h4, 4'hC, 4'hC, 4'h0, 4'h8, 4'h0, 4'h0};

    // register port request
    typedef struct packed {
        logic        we;
        logic        re;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } ivm_bus_req_t;

    // vector handed to the core
    typedef struct packed {
        logic        req;
        logic        trap;
        logic [6:0]  num;
        logic [3:0]  level;
        logic [23:0] addr;
    } ivm_vec_t;

endpackage

/* ivm_vector_mapper.sv */
`timescale 1ns/1ps

module ivm_vector_mapper (
    // clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  arst_n_i,
    // register port
    input  wire ivm_pkg::ivm_bus_req_t bus_i,
    output logic [15:0]                rdata_o,
    // request sources
    input  wire logic [1:0]            ext_pin_i,
    input  wire logic [5:0]            src_event_i,
    input  wire logic [3:0]            trap_event_i,
    // core side
    input  wire logic [3:0]            core_level_i,
    output ivm_pkg::ivm_vec_t          vec_o
);

    // whole module state
    typedef struct packed {
        logic                 alt;
        logic [3:0]           trap;
        logic [4:0][15:0]     flag;
        logic [4:0][15:0]     en;
        logic [6:0][15:0]     prio;
        logic [1:0]           pin_s1;
        logic [1:0]           pin_s2;
        logic [1:0]           pin_d;
        logic [15:0]          rdata;
        ivm_pkg::ivm_vec_t    vec;
    } ivm_state_t;

    ivm_state_t st;       // registered state
    ivm_state_t next_st;  // next value

    // 3-bit priority of source idx from the priority words
    function automatic logic [2:0] ivm_prio_of(input logic [6:0][15:0] pw, input int idx);
        logic [15:0] w;
        w = pw[ivm_pkg::IVM_SRC_PW[idx]];
        return 3'(w >> ivm_pkg::IVM_SRC_PL[idx]);
    endfunction

    // table slot address for a vector
    function automatic logic [23:0] ivm_slot_addr(input logic is_trap, input logic [6:0] num, input logic alt);
        logic [23:0] a;
        a = (is_trap ? ivm_pkg::IVM_TRAP_BASE : ivm_pkg::IVM_IRQ_BASE) + {16'h0000, num, 1'b0};
        if (alt) begin
            a = a + ivm_pkg::IVM_ALT_OFFSET;
        end
        return a;
    endfunction

    // eligibility per source, shared with the checks below
    logic [ivm_pkg::IVM_NUM_SRC-1:0] elig;
    always_comb begin
        for (int i = 0; i < ivm_pkg::IVM_NUM_SRC; i++) begin
            elig[i] = st.flag[ivm_pkg::IVM_SRC_FW[i]][ivm_pkg::IVM_SRC_FB[i]]
                    & st.en[ivm_pkg::IVM_SRC_FW[i]][ivm_pkg::IVM_SRC_FB[i]]
                    & ({1'b0, ivm_prio_of(st.prio, i)} > core_level_i);
        end
    end

    // next-state logic: sync, register port, flag setting, arbitration
    always_comb begin
        logic [1:0]                      rise;
        logic [ivm_pkg::IVM_NUM_SRC-1:0] set;
        logic                            found;
        logic [2:0]                      best_p;
        logic [6:0]                      best_n;
        logic [2:0]                      tnum;
        rise   = 2'b00;
        set    = '0;
        found  = 1'b0;
        best_p = 3'h0;
        best_n = 7'h00;
        tnum   = 3'h0;
        next_st = st;

        // pin synchroniser, then edge detect on the second stage only
        next_st.pin_s1 = ext_pin_i;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_d  = st.pin_s2;
        rise = st.pin_s2 & ~st.pin_d;

        // register writes
        if (bus_i.we) begin
            if (bus_i.addr == ivm_pkg::IVM_REG_CONTROL) begin
                next_st.alt = bus_i.wdata[ivm_pkg::IVM_ALT_BIT];
            end else if (bus_i.addr == ivm_pkg::IVM_REG_TRAP) begin
                next_st.trap = bus_i.wdata[4:1];
            end
            for (int k = 0; k < ivm_pkg::IVM_FLAG_WORDS; k++) begin
                if (bus_i.addr == ivm_pkg::IVM_REG_FLAG0 + 6'(k)) begin
                    next_st.flag[k] = bus_i.wdata;
                end
                if (bus_i.addr == ivm_pkg::IVM_REG_ENABLE0 + 6'(k)) begin
                    next_st.en[k] = bus_i.wdata;
                end
            end
            for (int k = 0; k < ivm_pkg::IVM_PRIO_WORDS; k++) begin
                if (bus_i.addr == ivm_pkg::IVM_REG_PRIO0 + 6'(k)) begin
                    next_st.prio[k] = bus_i.wdata;
                end
            end
        end

        // hardware sets after the write so a same-cycle clear loses
        set = {src_event_i[5:3], rise[1], src_event_i[2:0], rise[0]};
        for (int i = 0; i < ivm_pkg::IVM_NUM_SRC; i++) begin
            if (set[i]) begin
                next_st.flag[ivm_pkg::IVM_SRC_FW[i]][ivm_pkg::IVM_SRC_FB[i]] = 1'b1;
            end
        end
        next_st.trap = next_st.trap | trap_event_i;

        // read data, valid the cycle after the strobe only
        next_st.rdata = 16'h0000;
        if (bus_i.re) begin
            unique case (bus_i.addr)
                ivm_pkg::IVM_REG_CONTROL: next_st.rdata = {st.alt, 15'h0000};
                ivm_pkg::IVM_REG_TRAP:    next_st.rdata = {11'h000, st.trap, 1'b0};
                ivm_pkg::IVM_REG_VECTOR:  next_st.rdata = {8'h00, st.vec.req, st.vec.num};
                ivm_pkg::IVM_REG_LEVEL:   next_st.rdata = {11'h000, st.vec.trap, st.vec.level};
                default: begin
                    // word banks; anything else reads zero
                    for (int k = 0; k < ivm_pkg::IVM_FLAG_WORDS; k++) begin
                        if (bus_i.addr == ivm_pkg::IVM_REG_FLAG0 + 6'(k)) begin
                            next_st.rdata = st.flag[k];
                        end
                        if (bus_i.addr == ivm_pkg::IVM_REG_ENABLE0 + 6'(k)) begin
                            next_st.rdata = st.en[k];
                        end
                    end
                    for (int k = 0; k < ivm_pkg::IVM_PRIO_WORDS; k++) begin
                        if (bus_i.addr == ivm_pkg::IVM_REG_PRIO0 + 6'(k)) begin
                            next_st.rdata = st.prio[k];
                        end
                    end
                end
            endcase
        end

        // user arbitration; strict compare keeps the lower vector on a tie
        for (int i = 0; i < ivm_pkg::IVM_NUM_SRC; i++) begin
            if (elig[i] && (!found || ivm_prio_of(st.prio, i) > best_p)) begin
                found  = 1'b1;
                best_p = ivm_prio_of(st.prio, i);
                best_n = ivm_pkg::IVM_SRC_VEC[i];
            end
        end

        // traps are not maskable and outrank users; lowest trap first
        for (int t = ivm_pkg::IVM_NUM_TRAP - 1; t >= 0; t--) begin
            if (st.trap[t]) begin
                tnum = 3'(t + 1);
            end
        end

        if (|st.trap) begin
            next_st.vec.req   = 1'b1;
            next_st.vec.trap  = 1'b1;
            next_st.vec.num   = {4'h0, tnum};
            next_st.vec.level = ivm_pkg::IVM_TRAP_LEVEL;
            next_st.vec.addr  = ivm_slot_addr(1'b1, {4'h0, tnum}, st.alt);
        end else if (found) begin
            next_st.vec.req   = 1'b1;
            next_st.vec.trap  = 1'b0;
            next_st.vec.num   = best_n;
            next_st.vec.level = {1'b0, best_p};
            next_st.vec.addr  = ivm_slot_addr(1'b0, best_n, st.alt);
        end else begin
            // idle: nothing offered, address parked at zero
            next_st.vec = '0;
        end
    end

    // state register; reset clears everything, no vector is offered
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign rdata_o = st.rdata;
    assign vec_o   = st.vec;

    // alternate bit tracks the select bit at decision time
    a_alt_offset: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        vec_o.req |-> (vec_o.addr[8] == $past(st.alt)))
        else $error("vector address ignores table select");

    // trap addresses stay inside the trap block
    a_trap_range: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (vec_o.req && vec_o.trap) |-> (vec_o.addr[7:0] >= 8'h04 && vec_o.addr[7:0] <= 8'h12
                                       && vec_o.addr[7:0] == {vec_o.num[6:0], 1'b0} + 8'h04))
        else $error("trap slot address wrong");

    // interrupt slot address
    a_irq_addr: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (vec_o.req && !vec_o.trap) |-> (vec_o.addr[7:0] == {vec_o.num, 1'b0} + 8'h14)
                                       && (vec_o.addr[23:9] == 15'h0000))
        else $error("interrupt slot address wrong");

    // pending trap offered on the next cycle
    a_trap_first: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (st.trap[0]) |=> (vec_o.req && vec_o.trap && vec_o.num == 7'h01))
        else $error("oscillator trap not offered first");

    // request only above the core level
    a_core_mask: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (vec_o.req && !vec_o.trap) |-> (vec_o.level > $past(core_level_i)))
        else $error("masked source offered");

    // flag stays set until software writes
    a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        ($past(st.flag[0][13]) && !$past(bus_i.we)) |-> st.flag[0][13])
        else $error("flag cleared without write");

    // event beats a clear in the same cycle
    a_set_wins: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $past(src_event_i[0]) |-> st.flag[0][13])
        else $error("conversion event lost");

    // pin edge reaches the flag after the synchroniser
    a_pin_sync: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(ext_pin_i[0]) |-> ##3 st.flag[0][0])
        else $error("pin zero edge not flagged");

    // pin one takes the same three edges through the synchroniser
    a_pin_one: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(ext_pin_i[1]) |-> ##3 st.flag[1][4])
        else $error("pin one edge not flagged");

    // memory write event sets its flag on the next edge
    a_write_done_flag: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $past(src_event_i[1]) |-> st.flag[0][15])
        else $error("write done event lost");

    // change notify event lands in the second flag word
    a_change_flag: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $past(src_event_i[2]) |-> st.flag[1][3])
        else $error("change notify event lost");

    // calendar event lands in the third flag word
    a_rtc_flag: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $past(src_event_i[3]) |-> st.flag[2][14])
        else $error("calendar event lost");

    // voltage detect event lands in the fourth flag word
    a_level_flag: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $past(src_event_i[4]) |-> st.flag[3][8])
        else $error("voltage detect event lost");

    // wake-up event lands in the fifth flag word
    a_wake_flag: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $past(src_event_i[5]) |-> st.flag[4][0])
        else $error("wake-up event lost");

    // idle output parks every field at zero, as after reset
    a_idle_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !vec_o.req |-> (vec_o == '0))
        else $error("idle vector not zero");

    // a pending trap pre-empts every user source
    a_trap_wins: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (|st.trap) |=> (vec_o.req && vec_o.trap && vec_o.level == ivm_pkg::IVM_TRAP_LEVEL))
        else $error("trap did not pre-empt users");

    // reserved trap numbers are never offered
    a_trap_known: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (vec_o.req && vec_o.trap) |-> (vec_o.num >= 7'h01 && vec_o.num <= 7'h04))
        else $error("reserved trap offered");

    // user level is one of the seven requesting levels
    a_user_level: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (vec_o.req && !vec_o.trap) |-> (vec_o.level[3] == 1'b0 && vec_o.level != 4'h0))
        else $error("user level out of range");

    // equal priority goes to the lower vector
    a_tie_lower: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (elig == 8'h06 && st.trap == 4'h0 && ivm_prio_of(st.prio, 1) == ivm_prio_of(st.prio, 2))
         |=> (vec_o.num == 7'h0D))
        else $error("tie not given to lower vector");

endmodule

/* ivm_core_model.sv */
`timescale 1ns/1ps

// far side: core priority level plus the pin and event request sources
module ivm_core_model (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    // commands from the bench
    input  wire logic       fire_i,
    input  wire logic [2:0] src_i,
    input  wire logic [3:0] level_i,
    // toward the mapper
    output logic [1:0]      ext_pin_o,
    output logic [5:0]      src_event_o,
    output logic [3:0]      core_level_o
);
    logic [2:0] pin_cnt;  // pin hold, longer than the two-stage synchroniser

    // events pulse once, pins hold a level for several edges
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_pin_o    <= 2'h0;
            src_event_o  <= 6'h00;
            core_level_o <= 4'h0;
            pin_cnt      <= 3'h0;
        end else begin
            core_level_o <= level_i;
            src_event_o  <= 6'h00;
            if (pin_cnt != 3'h0) begin
                pin_cnt <= pin_cnt - 3'h1;
            end else begin
                ext_pin_o <= 2'h0;  // pin driven back low, never left floating
            end
            if (fire_i) begin
                if (src_i == 3'h0 || src_i == 3'h4) begin
                    ext_pin_o[src_i[2]] <= 1'b1;
                    pin_cnt             <= 3'h5;
                end else begin
                    src_event_o[(src_i < 3'h4) ? src_i - 3'h1 : src_i - 3'h2] <= 1'b1;
                end
            end
        end
    end
endmodule

/* ivm_vector_mapper_tb_top.sv */
`timescale 1ns/1ps

module ivm_vector_mapper_tb_top;
    logic                  clk_sys_i = 1'b0;
    logic                  arst_n_i  = 1'b0;
    ivm_pkg::ivm_bus_req_t bus       = '0;      // register port request
    logic [3:0]            trap_ev   = 4'h0;
    logic                  fire      = 1'b0;    // partner command strobe
    logic [2:0]            src       = 3'h0;
    logic [3:0]            lvl       = 4'h0;
    logic [1:0]            pins;
    logic [5:0]            evs;
    logic [3:0]            core_lvl;
    logic [15:0]           rdata;
    ivm_pkg::ivm_vec_t     vec;
    int                    num_errors = 0;
    int                    n_tests    = 0;
    logic [15:0]           exp_rd[$];            // notes of expected read data
    ivm_pkg::ivm_vec_t     exp_vec[$];           // notes of expected vectors
    logic                  rd_pend  = 1'b0;
    logic                  vec_pend = 1'b0;
    logic [7:0]            lfsr     = 8'h3a;
    logic [2:0]            p;
    logic                  alt;
    logic [5:0]            fa;
    logic [5:0]            ea;
    logic [5:0]            pa;
    // vector numbers in source order, kept apart from the design's map
    logic [6:0]            vnum [8] = '{7'h00, 7'h0d, 7'h0f, 7'h13, 7'h14, 7'h3e, 7'h48, 7'h50};

    always #4 clk_sys_i = ~clk_sys_i;

    ivm_vector_mapper ivm_vector_mapper_i (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus_i(bus), .rdata_o(rdata), .ext_pin_i(pins),
        .src_event_i(evs), .trap_event_i(trap_ev), .core_level_i(core_lvl), .vec_o(vec));
    ivm_core_model ivm_core_model_i (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .fire_i(fire), .src_i(src), .level_i(lvl),
        .ext_pin_o(pins), .src_event_o(evs), .core_level_o(core_lvl));

    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // expected vector: trap or user table, alternate adds a fixed offset
    function automatic ivm_pkg::ivm_vec_t mk(input logic t, input logic [6:0] n, input logic [3:0] l, input logic a);
        mk.req   = 1'b1;
        mk.trap  = t;
        mk.num   = n;
        mk.level = l;
        mk.addr  = (t ? 24'h00_0004 : 24'h00_0014) + {16'h0, n, 1'b0} + (a ? 24'h00_0100 : 24'h00_0000);
    endfunction

    task automatic cmp_rd(input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value rdata expected %h seen %h", e, s);
        end
    endtask

    task automatic cmp_vec(input ivm_pkg::ivm_vec_t e, input ivm_pkg::ivm_vec_t s);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value vector expected %h seen %h", e, s);
        end
    endtask

    // one write, then an idle cycle so strobes never get reassigned in one step
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        bus <= '0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        exp_rd.push_back(e);
        bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_sys_i);
        bus <= '0;
        @(posedge clk_sys_i);
    endtask

    task automatic chk_vec(input ivm_pkg::ivm_vec_t e);
        exp_vec.push_back(e);
        vec_pend <= 1'b1;
        @(posedge clk_sys_i);
        vec_pend <= 1'b0;
    endtask

    task automatic summarize;
        if (num_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // monitor: read data stand one cycle after the strobe, only there
    always @(posedge clk_sys_i) begin
        if (rd_pend) cmp_rd(exp_rd.pop_front(), rdata);
        if (vec_pend) cmp_vec(exp_vec.pop_front(), vec);
        rd_pend <= bus.re;
    end

    // watchdog: the run needs about 300 cycles, allow ten times more
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        num_errors++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        chk_vec('0);
        rd(ivm_pkg::IVM_REG_CONTROL, 16'h0000);
        // every source, random priority, tables alternating
        for (int s = 0; s < 8; s++) begin
            alt  = s[0];
            lfsr = nxt(lfsr);
            p    = 3'(lfsr % 7) + 3'h1;
            fa   = ivm_pkg::IVM_REG_FLAG0 + {3'h0, ivm_pkg::IVM_SRC_FW[s]};
            ea   = ivm_pkg::IVM_REG_ENABLE0 + {3'h0, ivm_pkg::IVM_SRC_FW[s]};
            pa   = ivm_pkg::IVM_REG_PRIO0 + {3'h0, ivm_pkg::IVM_SRC_PW[s]};
            wr(ivm_pkg::IVM_REG_CONTROL, {alt, 15'h0000});  // same handlers in both tables, only the slot moves
            wr(ea, 16'h0001 << ivm_pkg::IVM_SRC_FB[s]);
            wr(pa, {13'h0000, p} << ivm_pkg::IVM_SRC_PL[s]);
            lvl  <= {1'b0, p};
            fire <= 1'b1;
            src  <= s[2:0];
            @(posedge clk_sys_i);
            fire <= 1'b0;
            repeat (8) @(posedge clk_sys_i);
            chk_vec('0);
            lvl <= {1'b0, p - 3'h1};
            repeat (2) @(posedge clk_sys_i);
            chk_vec(mk(1'b0, vnum[s], {1'b0, p}, alt));
            rd(fa, 16'h0001 << ivm_pkg::IVM_SRC_FB[s]);
            wr(fa, 16'h0000);
            wr(ea, 16'h0000);
            wr(pa, 16'h0000);
            chk_vec('0);
        end
        // equal priority, then a raised one
        wr(ivm_pkg::IVM_REG_CONTROL, 16'h0000);
        wr(ivm_pkg::IVM_REG_ENABLE0, 16'ha000);
        wr(ivm_pkg::IVM_REG_PRIO0 + 6'h01, 16'h3030);
        lvl  <= 4'h0;
        fire <= 1'b1;
        src  <= 3'h2;
        @(posedge clk_sys_i);
        src <= 3'h1;
        @(posedge clk_sys_i);
        fire <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        chk_vec(mk(1'b0, 7'h0d, 4'h3, 1'b0));
        wr(ivm_pkg::IVM_REG_PRIO0 + 6'h01, 16'h4030);
        chk_vec(mk(1'b0, 7'h0f, 4'h4, 1'b0));
        // traps pre-empt the pending users, alternate on traps 2 and 4
        for (int t = 0; t < 4; t++) begin  // reserved traps 0, 5, 6, 7 are never raised
            trap_ev <= 4'h1 << t;
            @(posedge clk_sys_i);
            trap_ev <= 4'h0;
            wr(ivm_pkg::IVM_REG_CONTROL, {t[0], 15'h0000});
            chk_vec(mk(1'b1, 7'(t + 1), 4'hf, t[0]));
            rd(ivm_pkg::IVM_REG_TRAP, 16'h0001 << (t + 1));
            wr(ivm_pkg::IVM_REG_TRAP, 16'h0000);
        end
        chk_vec(mk(1'b0, 7'h0f, 4'h4, 1'b1));
        // vector number and level registers mirror the offered vector
        rd(ivm_pkg::IVM_REG_VECTOR, 16'h008f);
        rd(ivm_pkg::IVM_REG_LEVEL, 16'h0004);
        summarize();
    end
endmodule
